/* File: cpusr_consts.svh */
// Bit positions, reset values and encodings for the core status register set
`ifndef CPUSR_CONSTS_SVH
`define CPUSR_CONSTS_SVH

// ****************************************************************
// Status word field positions
// ****************************************************************
`define CPUSR_PSR_C         0
`define CPUSR_PSR_T         1
`define CPUSR_PSR_L         2
`define CPUSR_PSR_F         5
`define CPUSR_PSR_Z         6
`define CPUSR_PSR_N         7
`define CPUSR_PSR_U         8
`define CPUSR_PSR_S         9
`define CPUSR_PSR_P         10
`define CPUSR_PSR_I         11
`define CPUSR_PSR_B         12
`define CPUSR_PSR_RESET     16'h0000
`define CPUSR_PSR_HIGH_MSK  16'hFF00
`define CPUSR_PSR_LOW_MSK   16'h00FF

// ****************************************************************
// Setup word field positions
// ****************************************************************
`define CPUSR_CFG_I         0
`define CPUSR_CFG_F         1
`define CPUSR_CFG_M         2
`define CPUSR_CFG_C         3
`define CPUSR_CFG_DE        8
`define CPUSR_CFG_RESET     5'h00

// ****************************************************************
// Register selects and sizes
// ****************************************************************
`define CPUSR_NUM_GPR       8
`define CPUSR_AR_PC         3'h0
`define CPUSR_AR_ISP        3'h1
`define CPUSR_AR_USP        3'h2
`define CPUSR_AR_FP         3'h3
`define CPUSR_AR_SB         3'h4
`define CPUSR_AR_TBL        3'h5
`define CPUSR_AR_UNIT       3'h6
`define CPUSR_SZ_BYTE       2'h0
`define CPUSR_SZ_HALF       2'h1
`define CPUSR_LEN_BYTE      32'h00000001
`define CPUSR_LEN_HALF      32'h00000002
`define CPUSR_LEN_WORD      32'h00000004
`define CPUSR_WORD_RESET    32'h00000000
`define CPUSR_UNIT_RESET    16'h0000

`endif

/* File: cpusr_pkg.sv */
// Types shared by the core status register set
package cpusr_pkg;

   // ****************************************************************
   // Operations issued by the execute stage
   // ****************************************************************
   typedef enum logic [3:0] {
      CPUSR_OP_NOP      = 4'h0,
      CPUSR_OP_GPR_WR   = 4'h1,
      CPUSR_OP_AR_WR    = 4'h2,
      CPUSR_OP_PUSH     = 4'h3,
      CPUSR_OP_POP      = 4'h4,
      CPUSR_OP_PSR_WR   = 4'h5,
      CPUSR_OP_ADD      = 4'h6,
      CPUSR_OP_SUB      = 4'h7,
      CPUSR_OP_CMP      = 4'h8,
      CPUSR_OP_SETUP    = 4'h9,
      CPUSR_OP_IRQ_ACK  = 4'hA,
      CPUSR_OP_TRAP     = 4'hB,
      CPUSR_OP_RETI     = 4'hC,
      CPUSR_OP_BLT_GO   = 4'hD,
      CPUSR_OP_BLT_END  = 4'hE,
      CPUSR_OP_FP_INSTR = 4'hF
   } cpusr_op_t;

   typedef struct packed {
      cpusr_op_t   op;
      logic [2:0]  sel;
      logic [1:0]  size;
      logic        use_carry;
      logic        fp_cmp;
      logic        psr_lo_en;
      logic        psr_hi_en;
      logic [31:0] opa;
      logic [31:0] opb;
   } cpusr_cmd_t;

   typedef enum logic [1:0] {
      CPUSR_TR_IDLE = 2'b01,
      CPUSR_TR_PEND = 2'b10
   } cpusr_trace_t;

endpackage : cpusr_pkg

/* File: cpusr_regs.sv */
// Core register set: general, address, status and setup registers
`include "cpusr_consts.svh"

// Summary of operation
// - 32-bit general registers, narrow writes keep upper
// - Address registers 32 bits, unit pointer 16
// - Stack-select bit picks interrupt or user pointer
// - Push pre-decrements, pop post-increments by length
// - Program counter holds current instruction address
// - Status high byte writable only in supervisor
// - Carry flag from add/sub, consumed with carry
// - Trace enable traps once per instruction
// - Compare sets unsigned-less; float compare clears
// - Compare sets equal flag
// - Compare sets signed-less flag
// - Arithmetic reports overflow in general flag
// - User mode refuses privileged operations
// - Interrupt or trap clears stack-select bit
// - Interrupt enable masks all but non-maskable
// - Blit bit drives blit select low
// - Acknowledge clears five bits; return restores word
// - Setup word: five bits, setup instruction only
// - Setup vectoring bit selects vectored interrupts
// - No float unit: illegal opcode trap
// - Two setup bits select clock scaling
// - Direct exception bit enables fast exceptions
module cpusr_regs (
   input  wire logic               clk_i,
   input  wire logic               arst_n_i,
   input  wire cpusr_pkg::cpusr_cmd_t cmd_i,
   input  wire logic               instr_start_i,
   input  wire logic               instr_end_i,
   input  wire logic [31:0]        instr_addr_i,
   input  wire logic               irq_req_i,
   input  wire logic               nmi_req_i,
   input  wire logic [2:0]         rd_sel_i,
   output logic [31:0]             rd_data_o,
   output logic [31:0]             alu_result_o,
   output logic [31:0]             pc_o,
   output logic [31:0]             stack_addr_o,
   output logic [15:0]             psr_o,
   output logic                    priv_fault_o,
   output logic                    trace_trap_o,
   output logic                    irq_accept_o,
   output logic                    illegal_opcode_trap_o,
   output logic                    fpu_dispatch_o,
   output logic                    vectored_o,
   output logic [1:0]              clk_scale_o,
   output logic                    direct_exception_enable_o,
   output logic                    blit_unit_select_n_o
);

   // ****************************************************************
   // Storage
   // ****************************************************************
   logic [31:0]             gpr_q [`CPUSR_NUM_GPR];
   logic [31:0]             pc_q, isp_q, usp_q, fbp_q, sb_q, tbl_q;
   logic [15:0]             unit_q;
   logic [15:0]             psr_q, psr_d;
   logic [4:0]              cfg_q;
   logic                    blit_n_q;
   logic [31:0]             rd_q, res_q, sp_addr_q;
   logic                    fault_q, trc_q, acc_q, und_q, fpu_q;
   cpusr_pkg::cpusr_trace_t tr_q;

   logic                    user_mode;
   logic                    priv_op;
   logic                    refuse;
   logic [32:0]             sum;
   logic [31:0]             b_eff;
   logic                    cin;
   logic                    ovf;
   logic [31:0]             len;
   logic [31:0]             sp_cur;
   logic                    sp_write;
   logic [31:0]             sp_next;

   assign user_mode = psr_q[`CPUSR_PSR_U];
   assign priv_op = (cmd_i.op == cpusr_pkg::CPUSR_OP_SETUP)
                 || (cmd_i.op == cpusr_pkg::CPUSR_OP_RETI)
                 || (cmd_i.op == cpusr_pkg::CPUSR_OP_AR_WR
                     && cmd_i.sel != `CPUSR_AR_FP && cmd_i.sel != `CPUSR_AR_SB)
                 || (cmd_i.op == cpusr_pkg::CPUSR_OP_PSR_WR && cmd_i.psr_hi_en);
   assign refuse = user_mode && priv_op;

   // ****************************************************************
   // Arithmetic and compare
   // ****************************************************************
   // carry consumption
   assign cin   = cmd_i.use_carry & psr_q[`CPUSR_PSR_C];
   assign b_eff = (cmd_i.op == cpusr_pkg::CPUSR_OP_SUB) ? ~cmd_i.opb : cmd_i.opb;
   assign sum   = {1'b0, cmd_i.opa} + {1'b0, b_eff}
                + {32'h00000000, (cmd_i.op == cpusr_pkg::CPUSR_OP_SUB) ? ~cin : cin};
   assign ovf   = (cmd_i.opa[31] == b_eff[31]) && (sum[31] != cmd_i.opa[31]);

   // ****************************************************************
   // Stack pointer selection
   // ****************************************************************
   // active pointer
   assign sp_cur = psr_q[`CPUSR_PSR_S] ? usp_q : isp_q;
   always_comb
   begin
      case (cmd_i.size)
         `CPUSR_SZ_BYTE: len = `CPUSR_LEN_BYTE;
         `CPUSR_SZ_HALF: len = `CPUSR_LEN_HALF;
         default:        len = `CPUSR_LEN_WORD;
      endcase
   end
   assign sp_write = (cmd_i.op == cpusr_pkg::CPUSR_OP_PUSH)
                  || (cmd_i.op == cpusr_pkg::CPUSR_OP_POP);
   assign sp_next  = (cmd_i.op == cpusr_pkg::CPUSR_OP_PUSH) ? sp_cur - len : sp_cur + len;

   // ****************************************************************
   // General registers
   // ****************************************************************
   genvar g;
   generate
      for (g = 0; g < `CPUSR_NUM_GPR; g++)
      begin : g_gpr
         always_ff @(posedge clk_i or negedge arst_n_i)
         begin
            if (!arst_n_i)
               gpr_q[g] <= `CPUSR_WORD_RESET;
            else if (cmd_i.sel == 3'(g) && cmd_i.op == cpusr_pkg::CPUSR_OP_GPR_WR)
            begin
               case (cmd_i.size)
                  `CPUSR_SZ_BYTE: gpr_q[g][7:0]  <= cmd_i.opa[7:0];
                  `CPUSR_SZ_HALF: gpr_q[g][15:0] <= cmd_i.opa[15:0];
                  default:        gpr_q[g]       <= cmd_i.opa;
               endcase
            end
            else if (cmd_i.sel == 3'(g) && (cmd_i.op == cpusr_pkg::CPUSR_OP_ADD
                                        || cmd_i.op == cpusr_pkg::CPUSR_OP_SUB))
               gpr_q[g] <= sum[31:0];
         end
      end
   endgenerate

   always_ff @(posedge clk_i or negedge arst_n_i)
   begin
      if (!arst_n_i)
      begin
         rd_q  <= `CPUSR_WORD_RESET;
         res_q <= `CPUSR_WORD_RESET;
      end
      else
      begin
         rd_q <= gpr_q[rd_sel_i];
         if (cmd_i.op == cpusr_pkg::CPUSR_OP_ADD || cmd_i.op == cpusr_pkg::CPUSR_OP_SUB)
            res_q <= sum[31:0];
      end
   end

   // ****************************************************************
   // Address registers
   // ****************************************************************
   always_ff @(posedge clk_i or negedge arst_n_i)
   begin
      if (!arst_n_i)
      begin
         pc_q   <= `CPUSR_WORD_RESET;
         isp_q  <= `CPUSR_WORD_RESET;
         usp_q  <= `CPUSR_WORD_RESET;
         fbp_q  <= `CPUSR_WORD_RESET;
         sb_q   <= `CPUSR_WORD_RESET;
         tbl_q  <= `CPUSR_WORD_RESET;
         unit_q <= `CPUSR_UNIT_RESET;
      end
      else
      begin
         if (instr_start_i)
            pc_q <= instr_addr_i;
         else if (cmd_i.op == cpusr_pkg::CPUSR_OP_AR_WR && cmd_i.sel == `CPUSR_AR_PC && !refuse)
            pc_q <= cmd_i.opa;
         if (sp_write && psr_q[`CPUSR_PSR_S])
            usp_q <= sp_next;
         else if (sp_write)
            isp_q <= sp_next;
         if (cmd_i.op == cpusr_pkg::CPUSR_OP_AR_WR && !refuse)
         begin
            case (cmd_i.sel)
               `CPUSR_AR_ISP:  isp_q  <= cmd_i.opa;
               `CPUSR_AR_USP:  usp_q  <= cmd_i.opa;
               `CPUSR_AR_FP:   fbp_q  <= cmd_i.opa;
               `CPUSR_AR_SB:   sb_q   <= cmd_i.opa;
               `CPUSR_AR_TBL:  tbl_q  <= cmd_i.opa;
               `CPUSR_AR_UNIT: unit_q <= cmd_i.opa[15:0];
               default:        ;
            endcase
         end
      end
   end

   // Push presents the new pointer, pop the old one, as the memory address
   always_ff @(posedge clk_i or negedge arst_n_i)
   begin
      if (!arst_n_i)
         sp_addr_q <= `CPUSR_WORD_RESET;
      else if (cmd_i.op == cpusr_pkg::CPUSR_OP_PUSH)
         sp_addr_q <= sp_next;
      else if (cmd_i.op == cpusr_pkg::CPUSR_OP_POP)
         sp_addr_q <= sp_cur;
   end

   // ****************************************************************
   // Status word
   // ****************************************************************
   always_comb
   begin
      psr_d = psr_q;
      case (cmd_i.op)
         cpusr_pkg::CPUSR_OP_ADD,
         cpusr_pkg::CPUSR_OP_SUB:
         begin
            psr_d[`CPUSR_PSR_C] = (cmd_i.op == cpusr_pkg::CPUSR_OP_SUB) ? ~sum[32] : sum[32];
            psr_d[`CPUSR_PSR_F] = ovf;
         end
         cpusr_pkg::CPUSR_OP_CMP:
         begin
            psr_d[`CPUSR_PSR_L] = !cmd_i.fp_cmp && (cmd_i.opb < cmd_i.opa);
            psr_d[`CPUSR_PSR_Z] = (cmd_i.opb == cmd_i.opa);
            psr_d[`CPUSR_PSR_N] = ($signed(cmd_i.opb) < $signed(cmd_i.opa));
         end
         cpusr_pkg::CPUSR_OP_PSR_WR:
         begin
            if (cmd_i.psr_lo_en && !refuse)
               psr_d = (psr_d & `CPUSR_PSR_HIGH_MSK) | (cmd_i.opa[15:0] & `CPUSR_PSR_LOW_MSK);
            if (cmd_i.psr_hi_en && !refuse)
               psr_d = (psr_d & `CPUSR_PSR_LOW_MSK) | (cmd_i.opa[15:0] & `CPUSR_PSR_HIGH_MSK);
         end
         cpusr_pkg::CPUSR_OP_IRQ_ACK:
         begin
            psr_d[`CPUSR_PSR_B] = 1'b0;
            psr_d[`CPUSR_PSR_I] = 1'b0;
            psr_d[`CPUSR_PSR_P] = 1'b0;
            psr_d[`CPUSR_PSR_S] = 1'b0;
            psr_d[`CPUSR_PSR_U] = 1'b0;
         end
         cpusr_pkg::CPUSR_OP_TRAP:   psr_d[`CPUSR_PSR_S] = 1'b0;
         cpusr_pkg::CPUSR_OP_RETI:   psr_d = refuse ? psr_q : cmd_i.opa[15:0];
         cpusr_pkg::CPUSR_OP_BLT_GO:  psr_d[`CPUSR_PSR_B] = 1'b1;
         cpusr_pkg::CPUSR_OP_BLT_END: psr_d[`CPUSR_PSR_B] = 1'b0;
         default: ;
      endcase
      if (instr_start_i && psr_q[`CPUSR_PSR_T])
         psr_d[`CPUSR_PSR_P] = 1'b1;
      else if (instr_end_i && psr_q[`CPUSR_PSR_P])
         psr_d[`CPUSR_PSR_P] = 1'b0;
   end

   always_ff @(posedge clk_i or negedge arst_n_i)
   begin
      if (!arst_n_i)
      begin
         psr_q    <= `CPUSR_PSR_RESET;
         blit_n_q <= 1'b1;
      end
      else
      begin
         psr_q    <= psr_d;
         blit_n_q <= ~psr_d[`CPUSR_PSR_B];
      end
   end

   // ****************************************************************
   // Trace sequencing
   // ****************************************************************
   // one trap per instruction
   always_ff @(posedge clk_i or negedge arst_n_i)
   begin
      if (!arst_n_i)
      begin
         tr_q  <= cpusr_pkg::CPUSR_TR_IDLE;
         trc_q <= 1'b0;
      end
      else
      begin
         trc_q <= 1'b0;
         case (tr_q)
            cpusr_pkg::CPUSR_TR_IDLE:
               if (instr_start_i && psr_q[`CPUSR_PSR_T])
                  tr_q <= cpusr_pkg::CPUSR_TR_PEND;
            cpusr_pkg::CPUSR_TR_PEND:
               if (instr_end_i)
               begin
                  trc_q <= psr_q[`CPUSR_PSR_P];
                  tr_q  <= cpusr_pkg::CPUSR_TR_IDLE;
               end
            default: tr_q <= cpusr_pkg::CPUSR_TR_IDLE;
         endcase
      end
   end

   // ****************************************************************
   // Setup word and exception side effects
   // ****************************************************************
   always_ff @(posedge clk_i or negedge arst_n_i)
   begin
      if (!arst_n_i)
         cfg_q <= `CPUSR_CFG_RESET;
      else if (cmd_i.op == cpusr_pkg::CPUSR_OP_SETUP && !refuse)
         cfg_q <= {cmd_i.opa[`CPUSR_CFG_DE], cmd_i.opa[`CPUSR_CFG_C],
                   cmd_i.opa[`CPUSR_CFG_M], cmd_i.opa[`CPUSR_CFG_F], cmd_i.opa[`CPUSR_CFG_I]};
   end

   always_ff @(posedge clk_i or negedge arst_n_i)
   begin
      if (!arst_n_i)
      begin
         fault_q <= 1'b0;
         acc_q   <= 1'b0;
         und_q   <= 1'b0;
         fpu_q   <= 1'b0;
      end
      else
      begin
         fault_q <= refuse;
         acc_q   <= nmi_req_i || (irq_req_i && psr_q[`CPUSR_PSR_I]);
         und_q   <= (cmd_i.op == cpusr_pkg::CPUSR_OP_FP_INSTR) && !cfg_q[1];
         fpu_q   <= (cmd_i.op == cpusr_pkg::CPUSR_OP_FP_INSTR) && cfg_q[1];
      end
   end

   assign rd_data_o                 = rd_q;
   assign alu_result_o              = res_q;
   assign pc_o                      = pc_q;
   assign stack_addr_o              = sp_addr_q;
   assign psr_o                     = psr_q;
   assign priv_fault_o              = fault_q;
   assign trace_trap_o              = trc_q;
   assign irq_accept_o              = acc_q;
   assign illegal_opcode_trap_o     = und_q;
   assign fpu_dispatch_o            = fpu_q;
   assign vectored_o                = cfg_q[0];
   assign clk_scale_o               = cfg_q[3:2];
   assign direct_exception_enable_o = cfg_q[4];
   assign blit_unit_select_n_o      = blit_n_q;

   // ****************************************************************
   // Checks
   // ****************************************************************
   a_stack_select_push: assert property (@(posedge clk_i) disable iff (!arst_n_i)
      cmd_i.op == cpusr_pkg::CPUSR_OP_PUSH && !psr_q[`CPUSR_PSR_S]
      |=> isp_q == $past(isp_q) - $past(len) && usp_q == $past(usp_q))
      else $error("push did not move interrupt stack pointer");
   a_pop_address: assert property (@(posedge clk_i) disable iff (!arst_n_i)
      cmd_i.op == cpusr_pkg::CPUSR_OP_POP |=> stack_addr_o == $past(sp_cur))
      else $error("pop address is not the old pointer");
   a_user_high_byte: assert property (@(posedge clk_i) disable iff (!arst_n_i)
      user_mode && cmd_i.op == cpusr_pkg::CPUSR_OP_PSR_WR && cmd_i.psr_hi_en
      |=> psr_q == $past(psr_q) && priv_fault_o)
      else $error("user mode changed status high byte");
   a_cmp_equal: assert property (@(posedge clk_i) disable iff (!arst_n_i)
      cmd_i.op == cpusr_pkg::CPUSR_OP_CMP
      |=> psr_q[`CPUSR_PSR_Z] == ($past(cmd_i.opa) == $past(cmd_i.opb)))
      else $error("equal flag wrong after compare");
   a_trace_once: assert property (@(posedge clk_i) disable iff (!arst_n_i)
      trace_trap_o |=> !trace_trap_o)
      else $error("trace trap fired twice");
   a_ack_clears: assert property (@(posedge clk_i) disable iff (!arst_n_i)
      cmd_i.op == cpusr_pkg::CPUSR_OP_IRQ_ACK
      |=> !psr_q[`CPUSR_PSR_S] && !psr_q[`CPUSR_PSR_U] && !psr_q[`CPUSR_PSR_I]
          && blit_unit_select_n_o)
      else $error("acknowledge left status bits set");
   a_blit_select: assert property (@(posedge clk_i) disable iff (!arst_n_i)
      blit_unit_select_n_o == !psr_q[`CPUSR_PSR_B])
      else $error("blit select disagrees with blit bit");
   a_irq_mask: assert property (@(posedge clk_i) disable iff (!arst_n_i)
      irq_req_i && !nmi_req_i && !psr_q[`CPUSR_PSR_I] |=> !irq_accept_o)
      else $error("masked interrupt accepted");
   a_fp_trap: assert property (@(posedge clk_i) disable iff (!arst_n_i)
      cmd_i.op == cpusr_pkg::CPUSR_OP_FP_INSTR && !cfg_q[1]
      |=> illegal_opcode_trap_o && !fpu_dispatch_o)
      else $error("float instruction without unit not trapped");

endmodule : cpusr_regs

/* File: cpusr_regs_bench.sv */
// Self-checking bench for the core register set
`include "cpusr_consts.svh"

`define CHK(got, exp) \
   begin \
      num_checks++; \
      if ((got) !== (exp)) \
      begin \
         num_errors++; \
         $display("mismatch at %0t: got %h expected %h", $time, (got), (exp)); \
      end \
   end

module cpusr_regs_bench;
   timeunit 1ns;
   timeprecision 1ps;

   // ****************************************************************
   // Signals
   // ****************************************************************
   logic                  clk_i;
   logic                  arst_n_i;
   cpusr_pkg::cpusr_cmd_t cmd;
   logic                  instr_start_i;
   logic                  instr_end_i;
   logic [31:0]           instr_addr_i;
   logic                  irq_req_i;
   logic                  nmi_req_i;
   logic [2:0]            rd_sel_i;
   logic [31:0]           rd_data_o;
   logic [31:0]           alu_result_o;
   logic [31:0]           pc_o;
   logic [31:0]           stack_addr_o;
   logic [15:0]           psr_o;
   logic                  priv_fault_o;
   logic                  trace_trap_o;
   logic                  irq_accept_o;
   logic                  illegal_opcode_trap_o;
   logic                  fpu_dispatch_o;
   logic                  vectored_o;
   logic [1:0]            clk_scale_o;
   logic                  direct_exception_enable_o;
   logic                  blit_unit_select_n_o;
   int                    num_errors;
   int                    num_checks;
   logic [3:0]            cnt;
   cpusr_pkg::cpusr_cmd_t c;
   localparam logic [31:0] CMP_A [5] = '{32'h5, 32'h3, 32'h1, 32'h7, 32'h5};
   localparam logic [31:0] CMP_B [5] = '{32'h3, 32'h5, 32'hFFFFFFFF, 32'h7, 32'h3};

   cpusr_regs cpusr_regs_i (
      .clk_i                     (clk_i),
      .arst_n_i                  (arst_n_i),
      .cmd_i                     (cmd),
      .instr_start_i             (instr_start_i),
      .instr_end_i               (instr_end_i),
      .instr_addr_i              (instr_addr_i),
      .irq_req_i                 (irq_req_i),
      .nmi_req_i                 (nmi_req_i),
      .rd_sel_i                  (rd_sel_i),
      .rd_data_o                 (rd_data_o),
      .alu_result_o              (alu_result_o),
      .pc_o                      (pc_o),
      .stack_addr_o              (stack_addr_o),
      .psr_o                     (psr_o),
      .priv_fault_o              (priv_fault_o),
      .trace_trap_o              (trace_trap_o),
      .irq_accept_o              (irq_accept_o),
      .illegal_opcode_trap_o     (illegal_opcode_trap_o),
      .fpu_dispatch_o            (fpu_dispatch_o),
      .vectored_o                (vectored_o),
      .clk_scale_o               (clk_scale_o),
      .direct_exception_enable_o (direct_exception_enable_o),
      .blit_unit_select_n_o      (blit_unit_select_n_o)
   );

   initial
   begin
      clk_i = 1'b0;
      forever #12.5 clk_i = ~clk_i;
   end

   // ****************************************************************
   // Access tasks
   // ****************************************************************
   function automatic cpusr_pkg::cpusr_cmd_t mk(input cpusr_pkg::cpusr_op_t o,
      input logic [2:0] s, input logic [1:0] z, input logic [31:0] a, input logic [31:0] b);
      cpusr_pkg::cpusr_cmd_t r;
      r = '0;
      r.op = o;
      r.sel = s;
      r.size = z;
      r.opa = a;
      r.opb = b;
      return r;
   endfunction : mk

   // Leaves us 1 ns past the taking edge, so one-cycle pulses are still up
   task automatic op(input cpusr_pkg::cpusr_cmd_t x);
      @(posedge clk_i);
      cmd <= x;
      @(posedge clk_i);
      cmd <= '0;
      #1;
   endtask : op

   task automatic psr_wr(input logic [15:0] v, input logic lo, input logic hi);
      cpusr_pkg::cpusr_cmd_t x;
      x = mk(cpusr_pkg::CPUSR_OP_PSR_WR, 3'h0, 2'h0, {16'h0000, v}, 32'h0);
      x.psr_lo_en = lo;
      x.psr_hi_en = hi;
      op(x);
   endtask : psr_wr

   task automatic rd(input logic [2:0] n, input logic [31:0] exp);
      @(posedge clk_i);
      rd_sel_i <= n;
      @(posedge clk_i);
      #1;
      `CHK(rd_data_o, exp)
   endtask : rd

   task automatic pulse_instr(input logic start, input logic [31:0] a);
      @(posedge clk_i);
      instr_addr_i <= a;
      if (start)
         instr_start_i <= 1'b1;
      else
         instr_end_i <= 1'b1;
      @(posedge clk_i);
      instr_start_i <= 1'b0;
      instr_end_i <= 1'b0;
      #1;
   endtask : pulse_instr

   task automatic wait_cyc(input int n);
      repeat (n) @(posedge clk_i);
      #1;
   endtask : wait_cyc

   task automatic test_done;
      $display("checks %0d errors %0d", num_checks, num_errors);
      if (num_errors == 0 && num_checks > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask : test_done

   // ****************************************************************
   // Tests
   // ****************************************************************
   initial
   begin
      arst_n_i = 1'b0;
      cmd = '0;
      {instr_start_i, instr_end_i, irq_req_i, nmi_req_i} = 4'h0;
      instr_addr_i = 32'h00000000;
      rd_sel_i = 3'h0;
      num_errors = 0;
      num_checks = 0;
      repeat (12) @(posedge clk_i);
      arst_n_i <= 1'b1;
      #1;
      `CHK(psr_o, `CPUSR_PSR_RESET)
      `CHK(blit_unit_select_n_o, 1'b1)
      `CHK({vectored_o, clk_scale_o, direct_exception_enable_o}, 4'h0)
      $display("test reset done");
      op(mk(cpusr_pkg::CPUSR_OP_GPR_WR, 3'h1, 2'h2, 32'h11223344, 32'h0));
      op(mk(cpusr_pkg::CPUSR_OP_GPR_WR, 3'h1, `CPUSR_SZ_BYTE, 32'hFFFFFFAB, 32'h0));
      rd(3'h1, 32'h112233AB);
      op(mk(cpusr_pkg::CPUSR_OP_GPR_WR, 3'h1, `CPUSR_SZ_HALF, 32'hFFFFCDEF, 32'h0));
      rd(3'h1, 32'h1122CDEF);
      pulse_instr(1'b1, 32'h00400010);
      `CHK(pc_o, 32'h00400010)
      $display("test general and pc done");
      op(mk(cpusr_pkg::CPUSR_OP_AR_WR, `CPUSR_AR_ISP, 2'h2, 32'h00001000, 32'h0));
      op(mk(cpusr_pkg::CPUSR_OP_AR_WR, `CPUSR_AR_USP, 2'h2, 32'h00002000, 32'h0));
      op(mk(cpusr_pkg::CPUSR_OP_PUSH, 3'h0, 2'h2, 32'h0, 32'h0));
      `CHK(stack_addr_o, 32'h00000FFC)
      psr_wr(16'h0200, 1'b1, 1'b1);
      op(mk(cpusr_pkg::CPUSR_OP_PUSH, 3'h0, `CPUSR_SZ_HALF, 32'h0, 32'h0));
      `CHK(stack_addr_o, 32'h00001FFE)
      op(mk(cpusr_pkg::CPUSR_OP_POP, 3'h0, `CPUSR_SZ_HALF, 32'h0, 32'h0));
      `CHK(stack_addr_o, 32'h00001FFE)
      op(mk(cpusr_pkg::CPUSR_OP_PUSH, 3'h0, `CPUSR_SZ_BYTE, 32'h0, 32'h0));
      `CHK(stack_addr_o, 32'h00001FFF)
      $display("test stacks done");
      op(mk(cpusr_pkg::CPUSR_OP_ADD, 3'h2, 2'h2, 32'hFFFFFFFF, 32'h1));
      `CHK({alu_result_o, psr_o[`CPUSR_PSR_C]}, {32'h0, 1'b1})
      c = mk(cpusr_pkg::CPUSR_OP_ADD, 3'h2, 2'h2, 32'h1, 32'h2);
      c.use_carry = 1'b1;
      op(c);
      `CHK({alu_result_o, psr_o[`CPUSR_PSR_C]}, {32'h4, 1'b0})
      op(mk(cpusr_pkg::CPUSR_OP_ADD, 3'h2, 2'h2, 32'h7FFFFFFF, 32'h1));
      `CHK(psr_o[`CPUSR_PSR_F], 1'b1)
      op(mk(cpusr_pkg::CPUSR_OP_ADD, 3'h2, 2'h2, 32'hFFFFFFFF, 32'h1));
      // Equal operands make the borrow result independent of operand order
      c = mk(cpusr_pkg::CPUSR_OP_SUB, 3'h2, 2'h2, 32'h5, 32'h5);
      c.use_carry = 1'b1;
      op(c);
      `CHK({alu_result_o, psr_o[`CPUSR_PSR_C]}, {32'hFFFFFFFF, 1'b1})
      for (int i = 0; i < 5; i++)
      begin
         c = mk(cpusr_pkg::CPUSR_OP_CMP, 3'h0, 2'h2, CMP_A[i], CMP_B[i]);
         c.fp_cmp = (i == 4);
         op(c);
         `CHK(psr_o[`CPUSR_PSR_L], (i != 4) && (CMP_B[i] < CMP_A[i]))
         `CHK(psr_o[`CPUSR_PSR_Z], CMP_A[i] == CMP_B[i])
         `CHK(psr_o[`CPUSR_PSR_N], $signed(CMP_B[i]) < $signed(CMP_A[i]))
      end
      $display("test arithmetic done");
      op(mk(cpusr_pkg::CPUSR_OP_SETUP, 3'h0, 2'h2, 32'h0000010D, 32'h0));
      `CHK(vectored_o, 1'b1)
      `CHK(clk_scale_o, 2'h3)
      `CHK(direct_exception_enable_o, 1'b1)
      op(mk(cpusr_pkg::CPUSR_OP_FP_INSTR, 3'h0, 2'h2, 32'h0, 32'h0));
      `CHK({illegal_opcode_trap_o, fpu_dispatch_o}, 2'h2)
      op(mk(cpusr_pkg::CPUSR_OP_SETUP, 3'h0, 2'h2, 32'h00000006, 32'h0));
      `CHK({vectored_o, clk_scale_o, direct_exception_enable_o}, 4'h2)
      op(mk(cpusr_pkg::CPUSR_OP_FP_INSTR, 3'h0, 2'h2, 32'h0, 32'h0));
      `CHK({illegal_opcode_trap_o, fpu_dispatch_o}, 2'h1)
      $display("test setup done");
      psr_wr(16'h0002, 1'b1, 1'b1);
      pulse_instr(1'b1, 32'h00400020);
      `CHK(psr_o[`CPUSR_PSR_P], 1'b1)
      pulse_instr(1'b0, 32'h00400020);
      cnt = {3'h0, trace_trap_o};
      repeat (3)
      begin
         wait_cyc(1);
         cnt = cnt + {3'h0, trace_trap_o};
      end
      `CHK(cnt, 4'h1)
      $display("test trace done");
      psr_wr(16'h0A00, 1'b1, 1'b1);
      @(posedge clk_i);
      irq_req_i <= 1'b1;
      wait_cyc(2);
      `CHK(irq_accept_o, 1'b1)
      op(mk(cpusr_pkg::CPUSR_OP_TRAP, 3'h0, 2'h2, 32'h0, 32'h0));
      `CHK(psr_o, 16'h0800)
      psr_wr(16'h0300, 1'b1, 1'b1);
      op(mk(cpusr_pkg::CPUSR_OP_SETUP, 3'h0, 2'h2, 32'h00000001, 32'h0));
      `CHK({priv_fault_o, vectored_o}, 2'h2)
      psr_wr(16'h0000, 1'b0, 1'b1);
      `CHK({priv_fault_o, psr_o}, {1'b1, 16'h0300})
      psr_wr(16'h0001, 1'b1, 1'b0);
      `CHK(psr_o, 16'h0301)
      op(mk(cpusr_pkg::CPUSR_OP_BLT_GO, 3'h0, 2'h2, 32'h0, 32'h0));
      `CHK(blit_unit_select_n_o, 1'b0)
      op(mk(cpusr_pkg::CPUSR_OP_IRQ_ACK, 3'h0, 2'h2, 32'h0, 32'h0));
      `CHK({blit_unit_select_n_o, psr_o}, {1'b1, 16'h0001})
      wait_cyc(2);
      `CHK(irq_accept_o, 1'b0)
      @(posedge clk_i);
      nmi_req_i <= 1'b1;
      wait_cyc(2);
      `CHK(irq_accept_o, 1'b1)
      op(mk(cpusr_pkg::CPUSR_OP_RETI, 3'h0, 2'h2, 32'h00001A05, 32'h0));
      `CHK(psr_o, 16'h1A05)
      $display("test modes and interrupts done");
      test_done();
   end

   // Whole run needs about a hundred cycles; this margin only catches hangs
   initial
   begin
      #(25 * 5000);
      num_errors++;
      test_done();
   end

endmodule : cpusr_regs_bench
